// ### hdl/pms_pkg.sv
// Package of constants and types for the power mode sequencer
package pms_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [3:0] PMS_ADDR_CTRL   = 4'h0;
  localparam logic [3:0] PMS_ADDR_SLEEP  = 4'h4;
  localparam logic [3:0] PMS_ADDR_WAKEEN = 4'h8;
  localparam logic [3:0] PMS_ADDR_STATUS = 4'hC;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  // Control register
  localparam int PMS_CTRL_ANA_ON   = 0;
  localparam int PMS_CTRL_XCVR_CLK = 1;
  localparam int PMS_CTRL_FLASH_PD = 2;
  localparam int PMS_CTRL_DOZE     = 3;
  localparam int PMS_CTRL_WT_PD    = 4;
  localparam int PMS_CTRL_CMP_ON   = 5;
  localparam int PMS_CTRL_PCNT_ON  = 6;
  // Sleep request register
  localparam int PMS_SLP_GO        = 0;
  localparam int PMS_SLP_RAM_KEEP  = 1;
  localparam int PMS_SLP_OSC_KEEP  = 2;
  localparam int PMS_SLP_DEEP      = 3;
  // Wake source order
  localparam int PMS_WK_PIN        = 0;
  localparam int PMS_WK_TIMER      = 1;
  localparam int PMS_WK_CMP        = 2;
  localparam int PMS_WK_PCNT       = 3;
  localparam int PMS_WK_N          = 4;
  // Status word
  localparam int PMS_ST_SLEPT      = 0;
  localparam int PMS_ST_RAM_KEPT   = 1;
  localparam int PMS_ST_ANA_ON     = 2;
  localparam int PMS_ST_XCVR_CLK   = 3;
  localparam int PMS_ST_WDOG       = 4;
  localparam int PMS_ST_CLK32_RDY  = 5;
  localparam int PMS_ST_DEEP_EXIT  = 6;
  localparam int PMS_ST_WARM       = 7;
  localparam int PMS_ST_DOZE       = 8;

  // ----------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------
  localparam logic [6:0]  PMS_CTRL_RST   = 7'h02;
  localparam logic [3:0]  PMS_WAKEEN_RST = 4'h0;
  localparam logic [15:0] PMS_STATUS_W   = 16'h0000;
  localparam int          PMS_CLK_MHZ    = 40;
  localparam int          PMS_SETTLE_NS  = 250;
  localparam int          PMS_SETTLE_CYC = (PMS_SETTLE_NS * PMS_CLK_MHZ + 999) / 1000;
  localparam int          PMS_RELOAD_NS  = 1000;
  localparam int          PMS_RELOAD_CYC = (PMS_RELOAD_NS * PMS_CLK_MHZ + 999) / 1000;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    PMS_RUN    = 3'b000,
    PMS_ENTER  = 3'b001,
    PMS_SLEEP  = 3'b010,
    PMS_DEEP   = 3'b011,
    PMS_WAKE   = 3'b100,
    PMS_RELOAD = 3'b101,
    PMS_DOZE   = 3'b110
  } pms_state_t;

  // Power and clock switches for each domain
  typedef struct packed {
    logic dig_pwr;
    logic ana_pwr;
    logic ram_pwr;
    logic radio_pwr;
    logic osc32_pwr;
    logic wtimer_pwr;
    logic cmp_pwr;
    logic pcnt_pwr;
    logic sysclk_pwr;
    logic xflash_pwr;
    logic xcvr_clk_en;
    logic cpu_clk_en;
    logic pin_hold;
  } pms_pwr_t;

  // Restart indication towards the CPU
  typedef struct packed {
    logic start;
    logic warm;
    logic reload;
  } pms_boot_t;

endpackage : pms_pkg

// ### hdl/pms_power_mode_sequencer.sv
// Power mode sequencer: sleep, deep sleep, doze, domain and clock control
`timescale 1ns/100ps

module pms_power_mode_sequencer #(
  parameter int WAKE_N = pms_pkg::PMS_WK_N
) (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst_b,
  // Avalon-MM slave
  input  wire logic [3:0]            avs_address,
  input  wire logic                  avs_read,
  input  wire logic                  avs_write,
  input  wire logic [31:0]           avs_writedata,
  input  wire logic [3:0]            avs_byteenable,
  output logic      [31:0]           avs_readdata,
  output logic                       avs_waitrequest,
  // Wake and interrupt sources from pins and always-on blocks
  input  wire logic [WAKE_N-1:0]     wake_src,
  input  wire logic                  irq_any,
  input  wire logic                  wdog_restart,
  input  wire logic                  clk32_ready,
  // Domain switches and restart indication
  output pms_pkg::pms_pwr_t          pwr,
  output pms_pkg::pms_boot_t         boot
);
  import pms_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  pms_state_t        state_r;
  pms_state_t        state_nxt;
  logic [6:0]        ctrl_r;
  logic [2:0]        slp_cfg_r;        // Deep, osc keep, RAM keep
  logic [WAKE_N-1:0] wake_en_r;
  logic [WAKE_N-1:0] wake_s1_r;
  logic [WAKE_N-1:0] wake_s2_r;
  logic [WAKE_N-1:0] wake_d_r;
  logic [2:0]        misc_s1_r;
  logic [2:0]        misc_s2_r;
  logic              wake_pend_r;
  logic [7:0]        cnt_r;
  logic              slept_r;
  logic              ram_kept_r;
  logic              deep_exit_r;
  logic              warm_r;
  logic              wdog_r;
  logic              ack_r;
  logic              sleep_req;
  logic              doze_req;
  logic              pin_change;
  logic              wake_hit;
  logic              irq_s;
  logic              clk32_s;
  logic [15:0]       status_w;

  assign irq_s   = misc_s2_r[0];
  assign clk32_s = misc_s2_r[2];
  // Mode requests act at the taking edge, together with the register write
  assign sleep_req = avs_write && ack_r && avs_address == PMS_ADDR_SLEEP
                     && avs_byteenable[0] && avs_writedata[PMS_SLP_GO];
  assign doze_req  = avs_write && ack_r && avs_address == PMS_ADDR_CTRL
                     && avs_byteenable[0] && avs_writedata[PMS_CTRL_DOZE];

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  // Two stages for every outside input
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wake_s1_r <= '0;
      wake_s2_r <= '0;
      wake_d_r  <= '0;
      misc_s1_r <= '0;
      misc_s2_r <= '0;
    end else begin
      wake_s1_r <= wake_src;
      wake_s2_r <= wake_s1_r;
      wake_d_r  <= wake_s2_r;
      misc_s1_r <= {clk32_ready, wdog_restart, irq_any};
      misc_s2_r <= misc_s1_r;
    end
  end

  assign pin_change = wake_s2_r[PMS_WK_PIN] != wake_d_r[PMS_WK_PIN];
  assign wake_hit   = |(wake_s2_r & wake_en_r);

  // ----------------------------------------------------------------
  // Avalon-MM slave
  // ----------------------------------------------------------------
  // One wait cycle, then acknowledge; waitrequest is a flop of its own
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ack_r           <= 1'b0;
      avs_waitrequest <= 1'b1;
    end else begin
      ack_r           <= (avs_read || avs_write) && !ack_r;
      avs_waitrequest <= !((avs_read || avs_write) && !ack_r);
    end
  end

  // Software control registers
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ctrl_r    <= PMS_CTRL_RST;
      slp_cfg_r <= '0;
      wake_en_r <= PMS_WAKEEN_RST;
    end else begin
      if (avs_write && ack_r && avs_byteenable[0]) begin
        case (avs_address)
          PMS_ADDR_CTRL: begin
            ctrl_r[PMS_CTRL_ANA_ON]   <= avs_writedata[PMS_CTRL_ANA_ON];
            ctrl_r[PMS_CTRL_XCVR_CLK] <= avs_writedata[PMS_CTRL_XCVR_CLK];
            ctrl_r[PMS_CTRL_FLASH_PD] <= avs_writedata[PMS_CTRL_FLASH_PD];
            ctrl_r[PMS_CTRL_WT_PD]    <= avs_writedata[PMS_CTRL_WT_PD];
            ctrl_r[PMS_CTRL_CMP_ON]   <= avs_writedata[PMS_CTRL_CMP_ON];
            ctrl_r[PMS_CTRL_PCNT_ON]  <= avs_writedata[PMS_CTRL_PCNT_ON];
          end
          PMS_ADDR_SLEEP: begin
            slp_cfg_r <= avs_writedata[PMS_SLP_DEEP:PMS_SLP_RAM_KEEP];
          end
          PMS_ADDR_WAKEEN: begin
            wake_en_r <= avs_writedata[WAKE_N-1:0];
          end
          default: begin
          end
        endcase
      end else if (state_r == PMS_ENTER) begin
        ctrl_r[PMS_CTRL_ANA_ON] <= 1'b0;
      end
    end
  end

  // Status word
  always_comb begin
    status_w                   = PMS_STATUS_W;
    status_w[PMS_ST_SLEPT]     = slept_r;
    status_w[PMS_ST_RAM_KEPT]  = ram_kept_r;
    status_w[PMS_ST_ANA_ON]    = pwr.ana_pwr;
    status_w[PMS_ST_XCVR_CLK]  = pwr.xcvr_clk_en;
    status_w[PMS_ST_WDOG]      = wdog_r;
    status_w[PMS_ST_CLK32_RDY] = clk32_s;
    status_w[PMS_ST_DEEP_EXIT] = deep_exit_r;
    status_w[PMS_ST_WARM]      = warm_r;
    status_w[PMS_ST_DOZE]      = state_r == PMS_DOZE;
  end

  // Read data, registered at the wait cycle
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      avs_readdata <= '0;
    end else if (avs_read && !ack_r) begin
      case (avs_address)
        PMS_ADDR_CTRL:   avs_readdata <= {25'h000_0000, ctrl_r};
        PMS_ADDR_SLEEP:  avs_readdata <= {28'h000_0000, slp_cfg_r, 1'b0};
        PMS_ADDR_WAKEEN: avs_readdata <= {{(32-WAKE_N){1'b0}}, wake_en_r};
        PMS_ADDR_STATUS: avs_readdata <= {16'h0000, status_w};
        default:         avs_readdata <= '0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Mode state machine
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      PMS_RUN: begin
        if (sleep_req) begin
          state_nxt = PMS_ENTER;
        end else if (doze_req) begin
          state_nxt = PMS_DOZE;
        end
      end
      PMS_ENTER: begin
        if (cnt_r == '0) begin
          state_nxt = slp_cfg_r[2] ? PMS_DEEP : PMS_SLEEP;
        end
      end
      PMS_SLEEP: begin
        if (wake_hit || wake_pend_r) begin
          state_nxt = PMS_WAKE;
        end
      end
      PMS_DEEP: begin
        if (pin_change || wake_pend_r) begin
          state_nxt = PMS_WAKE;
        end
      end
      PMS_WAKE: begin
        if (cnt_r == '0) begin
          state_nxt = ram_kept_r ? PMS_RUN : PMS_RELOAD;
        end
      end
      PMS_RELOAD: begin
        if (cnt_r == '0) begin
          state_nxt = PMS_RUN;
        end
      end
      PMS_DOZE: begin
        if (irq_s) begin
          state_nxt = PMS_RUN;
        end
      end
      default: begin
        state_nxt = PMS_RUN;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_r <= PMS_RUN;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Settle and reload counter
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cnt_r <= '0;
    end else if (state_nxt != state_r) begin
      if (state_nxt == PMS_RELOAD) begin
        cnt_r <= 8'(PMS_RELOAD_CYC - 1);
      end else begin
        cnt_r <= 8'(PMS_SETTLE_CYC - 1);
      end
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wake_pend_r <= 1'b0;
    end else if (state_r == PMS_ENTER) begin
      if (slp_cfg_r[2] ? pin_change : wake_hit) begin
        wake_pend_r <= 1'b1;
      end
    end else begin
      wake_pend_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Sleep history and status flags
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      slept_r     <= 1'b0;
      ram_kept_r  <= 1'b0;
      deep_exit_r <= 1'b0;
      warm_r      <= 1'b0;
      wdog_r      <= 1'b0;
    end else begin
      // Watchdog restart seen, sticky; set wins over clear
      if (misc_s2_r[1]) begin
        wdog_r <= 1'b1;
      end else if (sleep_req) begin
        wdog_r <= 1'b0;
      end
      if (state_r == PMS_ENTER && state_nxt != PMS_ENTER) begin
        ram_kept_r  <= slp_cfg_r[0] && !slp_cfg_r[2];
        slept_r     <= 1'b0;
        deep_exit_r <= 1'b0;
      end else if (state_r == PMS_WAKE && state_nxt != PMS_WAKE) begin
        slept_r     <= 1'b1;
        deep_exit_r <= slp_cfg_r[2];
        warm_r      <= ram_kept_r;
      end
    end
  end

  // ----------------------------------------------------------------
  // Domain switches
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pwr  <= '{default: 1'b1, ana_pwr: 1'b0};
      boot <= '0;
    end else begin
      case (state_nxt)
        PMS_SLEEP, PMS_DEEP: begin
          pwr.dig_pwr     <= 1'b0;
          pwr.ana_pwr     <= 1'b0;
          pwr.radio_pwr   <= 1'b0;
          pwr.ram_pwr     <= slp_cfg_r[0] && state_nxt == PMS_SLEEP;
          pwr.osc32_pwr   <= slp_cfg_r[1] && state_nxt == PMS_SLEEP;
          pwr.wtimer_pwr  <= slp_cfg_r[1] && state_nxt == PMS_SLEEP
                             && !ctrl_r[PMS_CTRL_WT_PD];
          pwr.cmp_pwr     <= ctrl_r[PMS_CTRL_CMP_ON] && state_nxt == PMS_SLEEP;
          pwr.pcnt_pwr    <= ctrl_r[PMS_CTRL_PCNT_ON] && state_nxt == PMS_SLEEP;
          pwr.sysclk_pwr  <= state_nxt == PMS_SLEEP;
          pwr.xflash_pwr  <= state_nxt == PMS_SLEEP && !ctrl_r[PMS_CTRL_FLASH_PD];
          pwr.xcvr_clk_en <= 1'b0;
          pwr.cpu_clk_en  <= 1'b0;
          pwr.pin_hold    <= 1'b1;
        end
        PMS_ENTER: begin
          pwr.pin_hold    <= 1'b1;
          pwr.cpu_clk_en  <= 1'b0;
        end
        PMS_DOZE: begin
          pwr.cpu_clk_en  <= 1'b0;
        end
        default: begin
          pwr.dig_pwr     <= 1'b1;
          pwr.radio_pwr   <= 1'b1;
          pwr.ram_pwr     <= 1'b1;
          pwr.osc32_pwr   <= 1'b1;
          pwr.wtimer_pwr  <= 1'b1;
          pwr.cmp_pwr     <= 1'b1;
          pwr.pcnt_pwr    <= 1'b1;
          pwr.sysclk_pwr  <= 1'b1;
          pwr.xflash_pwr  <= !ctrl_r[PMS_CTRL_FLASH_PD];
          pwr.ana_pwr     <= ctrl_r[PMS_CTRL_ANA_ON];
          pwr.xcvr_clk_en <= ctrl_r[PMS_CTRL_XCVR_CLK];
          pwr.cpu_clk_en  <= state_nxt == PMS_RUN;
          pwr.pin_hold    <= state_nxt != PMS_RUN;
        end
      endcase
      boot.reload <= state_nxt == PMS_RELOAD;
      boot.start  <= state_r != PMS_RUN && state_r != PMS_DOZE && state_nxt == PMS_RUN;
      boot.warm   <= ram_kept_r;
    end
  end

endmodule : pms_power_mode_sequencer

// ### tb/pms_seq_properties.sv
// Concurrent checks on the power mode sequencer ports
`timescale 1ns/100ps
module pms_seq_properties
  import pms_pkg::*;
#(
  parameter int WAKE_N = pms_pkg::PMS_WK_N
) (
  // Clock and reset
  input wire logic               clk,
  input wire logic               rst_b,
  // Register bus
  input wire logic [3:0]         avs_address,
  input wire logic               avs_read,
  input wire logic               avs_write,
  input wire logic [31:0]        avs_writedata,
  input wire logic [3:0]         avs_byteenable,
  input wire logic [31:0]        avs_readdata,
  input wire logic               avs_waitrequest,
  // Wake and status inputs
  input wire logic [WAKE_N-1:0]  wake_src,
  input wire logic               irq_any,
  input wire logic               wdog_restart,
  input wire logic               clk32_ready,
  // Domain switches and restart
  input wire pms_pkg::pms_pwr_t  pwr,
  input wire pms_pkg::pms_boot_t boot
);
  import pms_pkg::*;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  bus_answer_a : assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer not one cycle after request");
  bus_release_a : assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("bus answer held too long");
  sleep_domains_a : assert property (
    !pwr.dig_pwr |-> !pwr.radio_pwr && !pwr.ana_pwr && pwr.pin_hold)
    else $error("domain powered or pins free in sleep");
  doze_power_a : assert property (
    !pwr.cpu_clk_en && pwr.dig_pwr |-> pwr.radio_pwr && pwr.ram_pwr && pwr.sysclk_pwr)
    else $error("doze dropped more than the cpu clock");
  doze_exit_a : assert property (
    !pwr.cpu_clk_en && pwr.dig_pwr && irq_any |-> ##[1:5] pwr.cpu_clk_en)
    else $error("interrupt did not end doze");
  xcvr_gate_a : assert property (
    avs_write && !avs_waitrequest && avs_address == PMS_ADDR_CTRL && avs_byteenable[0]
    && !avs_writedata[PMS_CTRL_XCVR_CLK] && pwr.dig_pwr |-> ##[1:2] !pwr.xcvr_clk_en)
    else $error("transceiver clock not gated");
  gate_source_a : assert property (
    !pwr.xcvr_clk_en && pwr.dig_pwr |-> pwr.radio_pwr)
    else $error("gated clock source lost power");
  deep_domains_a : assert property (
    !pwr.sysclk_pwr |-> !pwr.ram_pwr && !pwr.xflash_pwr && !pwr.osc32_pwr && !pwr.dig_pwr)
    else $error("domain left powered in deep sleep");
  deep_hold_a : assert property (
    (!pwr.sysclk_pwr && $stable(wake_src[PMS_WK_PIN])) [*8] |=> !pwr.sysclk_pwr)
    else $error("deep sleep left without pin change");
  reload_cold_a : assert property (boot.reload |-> !boot.warm)
    else $error("reload on warm restart");
endmodule : pms_seq_properties

// ### tb/test_power_mode_sequencer.sv
// Self-checking testbench for the power mode sequencer
`timescale 1ns/100ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin miscompares++; \
  $display("unexpected %s: expected %0h, seen %0h", n, e, g); end end
`define WAITF(c) while (!(c)) @(negedge clk);
module test_power_mode_sequencer;
  import pms_pkg::*;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        clk, rst_b, avs_read, avs_write, avs_waitrequest;
  logic        irq_any, wdog_restart, clk32_ready, saw_reload;
  logic [3:0]  avs_address, avs_byteenable, wake_src;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [1:0]  src;
  pms_pwr_t    pwr;
  pms_boot_t   boot;
  int          compares, miscompares, cyc;

  // Clock generation
  always #12.5 clk = ~clk;

  // Device under test
  pms_power_mode_sequencer dut_u (.clk(clk), .rst_b(rst_b), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .wake_src(wake_src), .irq_any(irq_any),
    .wdog_restart(wdog_restart), .clk32_ready(clk32_ready), .pwr(pwr), .boot(boot));

  // Cycle ceiling and reload watch
  always @(posedge clk) begin
    cyc++;
    if (boot.reload === 1'b1) saw_reload = 1'b1;
    if (cyc == 5000) begin
      miscompares++;
      wrap_up();
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic wrap_up();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : wrap_up

  // One bus access; request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d,
                     input logic be);
    @(posedge clk);
    avs_address    <= a;
    avs_write      <= wr;
    avs_read       <= !wr;
    avs_writedata  <= {24'h00_0000, d};
    avs_byteenable <= {3'h7, be};
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask : bus

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0; rst_b = 1'b0; avs_read = 1'b0; avs_write = 1'b0; avs_address = 4'h0;
    avs_writedata = 32'h0000_0000; avs_byteenable = 4'hf; wake_src = 4'h0;
    irq_any = 1'b0; wdog_restart = 1'b0; clk32_ready = 1'b0; saw_reload = 1'b0;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    @(negedge clk);
    `CHK("reset pwr", 13'h17ff, pwr)
    bus(1'b0, PMS_ADDR_CTRL, 8'h00, 1'b1);
    `CHK("ctrl reset", 32'h0000_0002, rd)
    bus(1'b0, 4'h1, 8'h00, 1'b1);
    `CHK("unmapped", 32'h0000_0000, rd)
    bus(1'b1, PMS_ADDR_CTRL, 8'h03, 1'b1);
    repeat (2) @(negedge clk);
    `CHK("ana on", 1'b1, pwr.ana_pwr)
    bus(1'b1, PMS_ADDR_CTRL, 8'h00, 1'b0);
    bus(1'b0, PMS_ADDR_CTRL, 8'h00, 1'b1);
    `CHK("lane off write", 32'h0000_0003, rd)
    bus(1'b1, PMS_ADDR_CTRL, 8'h01, 1'b1);
    repeat (2) @(negedge clk);
    `CHK("gate", 2'b01, {pwr.xcvr_clk_en, pwr.radio_pwr})
    bus(1'b0, PMS_ADDR_STATUS, 8'h00, 1'b1);
    `CHK("status ana clk", 2'b01, rd[3:2])
    bus(1'b1, PMS_ADDR_CTRL, 8'h03, 1'b1);
    repeat (2) @(negedge clk);
    `CHK("ungate", 1'b1, pwr.xcvr_clk_en)
    @(posedge clk);
    wdog_restart <= 1'b1;
    clk32_ready  <= 1'b1;
    @(posedge clk);
    wdog_restart <= 1'b0;
    repeat (4) @(posedge clk);
    bus(1'b0, PMS_ADDR_STATUS, 8'h00, 1'b1);
    `CHK("status wdog 32k", 2'b11, rd[5:4])
    // Doze and interrupt exit
    bus(1'b1, PMS_ADDR_CTRL, 8'h0b, 1'b1);
    `WAITF(pwr.cpu_clk_en === 1'b0)
    `CHK("doze pwr", 5'h1f, {pwr.dig_pwr, pwr.radio_pwr, pwr.ram_pwr, pwr.sysclk_pwr,
                            pwr.xcvr_clk_en})
    bus(1'b0, PMS_ADDR_STATUS, 8'h00, 1'b1);
    `CHK("status doze", 1'b1, rd[8])
    irq_any <= 1'b1;
    `WAITF(pwr.cpu_clk_en === 1'b1)
    @(posedge clk);
    irq_any <= 1'b0;
    // Four sleep variants, one wake source each
    for (int v = 0; v < 4; v++) begin
      src = {v[0], v[1]};
      bus(1'b1, PMS_ADDR_WAKEEN, 8'h01 << src, 1'b1);
      // Counter kept only with the oscillator; flash and timers dropped last
      bus(1'b1, PMS_ADDR_CTRL, (v == 3) ? 8'h77 : (v == 2) ? 8'h63 : 8'h23, 1'b1);
      saw_reload = 1'b0;
      bus(1'b1, PMS_ADDR_SLEEP, {5'h00, v[1], v[0], 1'b1}, 1'b1);
      if (v != 1) begin
        `WAITF(pwr.dig_pwr === 1'b0)
        `CHK("sleep pwr", {3'b001, v[0], v[1], v[1] && v != 3, 1'b1, v[1], v != 3},
             {pwr.ana_pwr, pwr.radio_pwr, pwr.pin_hold, pwr.ram_pwr, pwr.osc32_pwr,
              pwr.wtimer_pwr, pwr.cmp_pwr, pwr.pcnt_pwr, pwr.xflash_pwr})
        @(posedge clk);
        wake_src <= 4'h1 << (src + 2'd1);
        repeat (20) @(negedge clk);
        `CHK("disabled wake", 1'b0, pwr.dig_pwr)
      end
      @(posedge clk);
      wake_src <= 4'h1 << src;
      if (v == 1) begin
        // One-cycle pulse during entry must still wake
        @(posedge clk);
        wake_src <= 4'h0;
      end
      `WAITF(boot.start === 1'b1)
      `CHK("warm", v[0], boot.warm)
      `CHK("reload", !v[0], saw_reload)
      @(posedge clk);
      wake_src <= 4'h0;
      bus(1'b0, PMS_ADDR_STATUS, 8'h00, 1'b1);
      `CHK("status wake", {v[0], v[0], 1'b1}, {rd[7], rd[1:0]})
    end
    // Deep sleep left only by pin change
    bus(1'b1, PMS_ADDR_WAKEEN, 8'h0f, 1'b1);
    bus(1'b0, PMS_ADDR_WAKEEN, 8'h00, 1'b1);
    `CHK("wake enables", 32'h0000_000f, rd)
    bus(1'b1, PMS_ADDR_SLEEP, 8'h0b, 1'b1);
    `WAITF(pwr.sysclk_pwr === 1'b0)
    `CHK("deep pwr", 6'h00, {pwr.ram_pwr, pwr.xflash_pwr, pwr.osc32_pwr, pwr.dig_pwr,
                             pwr.cpu_clk_en, pwr.xcvr_clk_en})
    @(posedge clk);
    wake_src <= 4'he;
    repeat (20) @(negedge clk);
    `CHK("deep other src", 1'b0, pwr.sysclk_pwr)
    @(posedge clk);
    wake_src <= 4'hf;
    `WAITF(boot.start === 1'b1)
    bus(1'b0, PMS_ADDR_STATUS, 8'h00, 1'b1);
    `CHK("status deep", 2'b10, {rd[6], rd[1]})
    wrap_up();
  end
endmodule : test_power_mode_sequencer

// Attach the port checker
bind pms_power_mode_sequencer pms_seq_properties #(.WAKE_N(WAKE_N)) chk_u (
  .clk(clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .wake_src(wake_src),
  .irq_any(irq_any), .wdog_restart(wdog_restart), .clk32_ready(clk32_ready),
  .pwr(pwr), .boot(boot));
